/* rtl/link_layer_dllp_request_status.sv */
// Link-layer packet request, send acknowledge and state indication.
// Functional notes
// - Command 00 is idle; nothing is transmitted while it is held.
// - Command 01 transmits a power-management packet with the given type.
// - Command 10 transmits a vendor packet carrying the 24-bit payload.
// - Power types: 000 L1, 001 L2, 011 ASPM L1 request, 100 ack.
// - The sent output tells the user a requested packet went out.
// - Inactive flag is high while the link layer is inactive.
// - Initialising flag is high during initialisation, flow-control setup included.
// - Active flag is high while the link layer is active.
// - Up flag is high only when active and forwarding received packets.
`default_nettype none
module link_layer_dllp_request_status (
    input wire logic sys_clk,
    input wire logic srst,
    // User request side
    input wire logic [1:0] send_cmd,
    input wire logic [2:0] pm_type,
    input wire logic [23:0] vendor_payload,
    output logic packet_sent,
    output logic link_layer_inactive_flag,
    output logic link_layer_initialising_flag,
    output logic link_layer_active_flag,
    output logic link_layer_up_flag,
    // Physical side
    input wire logic phy_link_up,
    input wire logic fc_init_done,
    output dllp_pkg::dllp_t tx_dllp,
    output logic tx_dllp_valid,
    input wire logic tx_dllp_ready,
    // AXI4-Lite register slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Returns 0 for control, 1 for status, 2 for an unmapped word.
    function automatic logic [1:0] reg_sel(input logic [3:0] addr);
        return (addr == dllp_pkg::CTRL_OFFSET) ? 2'h0
            : (addr == dllp_pkg::STATUS_OFFSET) ? 2'h1 : 2'h2;
    endfunction

    // ------------------------------------------------------------
    // Link-layer state machine
    // ------------------------------------------------------------
    dllp_pkg::link_state_t ls_q, ls_d;
    dllp_pkg::link_flags_t flags_q, flags_d;
    logic [1:0] ctrl_q, ctrl_d;

    always_comb begin
        ls_d = ls_q;
        case (ls_q)
            dllp_pkg::LS_INACTIVE: begin
                if (ctrl_q[dllp_pkg::CTRL_LINK_EN_BIT] && phy_link_up) begin
                    ls_d = dllp_pkg::LS_INIT;
                end
            end
            dllp_pkg::LS_INIT: begin
                if (fc_init_done) begin
                    ls_d = dllp_pkg::LS_ACTIVE;
                end
            end
            dllp_pkg::LS_ACTIVE: ls_d = dllp_pkg::LS_ACTIVE;
            default: ls_d = dllp_pkg::LS_INACTIVE;
        endcase
        // Losing the physical link or the enable drops straight out.
        if (!phy_link_up || !ctrl_q[dllp_pkg::CTRL_LINK_EN_BIT]) begin
            ls_d = dllp_pkg::LS_INACTIVE;
        end
        // Flags decode the next state so they line up with the state.
        flags_d.inactive = (ls_d == dllp_pkg::LS_INACTIVE);
        flags_d.initialising = (ls_d == dllp_pkg::LS_INIT);
        flags_d.active = (ls_d == dllp_pkg::LS_ACTIVE);
        flags_d.up = (ls_d == dllp_pkg::LS_ACTIVE)
            && ctrl_d[dllp_pkg::CTRL_TLP_FWD_BIT];
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ls_q <= dllp_pkg::LS_INACTIVE;
            flags_q <= '{inactive: 1'b1, default: 1'b0};
        end else begin
            ls_q <= ls_d;
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------
    // Packet send sequencer
    // ------------------------------------------------------------
    // A request is only taken while the link is active; packets cannot
    // go out before flow control is set up. After the send the command
    // must return to idle, so a held command is not sent twice.
    dllp_pkg::send_state_t ss_q, ss_d;
    dllp_pkg::dllp_t pkt_q, pkt_d;
    logic sent_q, sent_d, valid_q, valid_d;
    logic [15:0] count_q, count_d;

    always_comb begin
        ss_d = ss_q;
        pkt_d = pkt_q;
        sent_d = 1'b0;
        count_d = count_q;
        case (ss_q)
            dllp_pkg::SS_IDLE: begin
                if (flags_q.active && (send_cmd == dllp_pkg::CMD_PM
                        || send_cmd == dllp_pkg::CMD_VENDOR)) begin
                    pkt_d.kind = send_cmd;
                    pkt_d.pm_type = (send_cmd == dllp_pkg::CMD_PM) ?
                        pm_type : 3'h0;
                    pkt_d.payload = (send_cmd == dllp_pkg::CMD_VENDOR) ?
                        vendor_payload : 24'h000000;
                    ss_d = dllp_pkg::SS_SEND;
                end
            end
            dllp_pkg::SS_SEND: begin
                if (tx_dllp_ready) begin
                    sent_d = 1'b1;
                    count_d = count_q + 16'h0001;
                    ss_d = dllp_pkg::SS_RELEASE;
                end
            end
            dllp_pkg::SS_RELEASE: begin
                if (send_cmd == dllp_pkg::CMD_NONE) begin
                    ss_d = dllp_pkg::SS_IDLE;
                end
            end
            default: ss_d = dllp_pkg::SS_IDLE;
        endcase
        // A link drop abandons a packet that has not gone out yet.
        if (!flags_q.active && ss_q == dllp_pkg::SS_SEND) begin
            ss_d = dllp_pkg::SS_RELEASE;
        end
        valid_d = (ss_d == dllp_pkg::SS_SEND);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ss_q <= dllp_pkg::SS_IDLE;
            pkt_q <= '0;
            sent_q <= 1'b0;
            valid_q <= 1'b0;
            count_q <= 16'h0000;
        end else begin
            ss_q <= ss_d;
            pkt_q <= pkt_d;
            sent_q <= sent_d;
            valid_q <= valid_d;
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite register slave
    // ------------------------------------------------------------
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [3:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (aw_have_d && w_have_d && !bvalid_d) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = dllp_pkg::RESP_OKAY;
            if (reg_sel(aw_addr_d) == 2'h2) begin
                bresp_d = dllp_pkg::RESP_SLVERR;
            end else if (reg_sel(aw_addr_d) == 2'h0 && w_strb_d[0]) begin
                ctrl_d = w_data_d[1:0];
            end
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = 32'h00000000;
            rresp_d = dllp_pkg::RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                2'h0: rdata_d[1:0] = ctrl_q;
                2'h1: begin
                    rdata_d[dllp_pkg::STAT_INACTIVE_BIT] = flags_q.inactive;
                    rdata_d[dllp_pkg::STAT_INIT_BIT] = flags_q.initialising;
                    rdata_d[dllp_pkg::STAT_ACTIVE_BIT] = flags_q.active;
                    rdata_d[dllp_pkg::STAT_UP_BIT] = flags_q.up;
                    rdata_d[dllp_pkg::STAT_BUSY_BIT] =
                        (ss_q != dllp_pkg::SS_IDLE);
                    rdata_d[dllp_pkg::STAT_COUNT_LSB +: 16] = count_q;
                end
                default: rresp_d = dllp_pkg::RESP_SLVERR;
            endcase
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= dllp_pkg::RESP_OKAY;
            ctrl_q <= dllp_pkg::CTRL_RESET;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= dllp_pkg::RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            ctrl_q <= ctrl_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign packet_sent = sent_q;
    assign link_layer_inactive_flag = flags_q.inactive;
    assign link_layer_initialising_flag = flags_q.initialising;
    assign link_layer_active_flag = flags_q.active;
    assign link_layer_up_flag = flags_q.up;
    assign tx_dllp = pkt_q;
    assign tx_dllp_valid = valid_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

/* rtl/dllp_pkg.sv */
// Shared constants and types for the link-layer packet request block.
`default_nettype none
package dllp_pkg;
    // ------------------------------------------------------------
    // Send command and power message encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_PM = 2'h1;
    localparam logic [1:0] CMD_VENDOR = 2'h2;
    localparam logic [1:0] CMD_RESERVED = 2'h3;
    localparam logic [2:0] PM_ENTER_L1 = 3'h0;
    localparam logic [2:0] PM_ENTER_L2 = 3'h1;
    localparam logic [2:0] PM_ASPM_L1_REQ = 3'h3;
    localparam logic [2:0] PM_REQ_ACK = 3'h4;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam int CTRL_LINK_EN_BIT = 0;
    localparam int CTRL_TLP_FWD_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STAT_INACTIVE_BIT = 0;
    localparam int STAT_INIT_BIT = 1;
    localparam int STAT_ACTIVE_BIT = 2;
    localparam int STAT_UP_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_COUNT_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] kind;
        logic [2:0] pm_type;
        logic [23:0] payload;
    } dllp_t;

    typedef struct packed {
        logic inactive;
        logic initialising;
        logic active;
        logic up;
    } link_flags_t;

    typedef enum logic [1:0] {
        LS_INACTIVE = 2'b00,
        LS_INIT = 2'b01,
        LS_ACTIVE = 2'b10
    } link_state_t;

    typedef enum logic [1:0] {
        SS_IDLE = 2'b00,
        SS_SEND = 2'b01,
        SS_RELEASE = 2'b10
    } send_state_t;
endpackage
`default_nettype wire

/* test/dllp_req_chk.sv */
// Concurrent checks on the link-layer packet request block ports.
`default_nettype none
module dllp_req_chk (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [1:0] send_cmd,
    input wire logic [2:0] pm_type,
    input wire logic [23:0] vendor_payload,
    input wire logic packet_sent,
    input wire logic link_layer_inactive_flag,
    input wire logic link_layer_initialising_flag,
    input wire logic link_layer_active_flag,
    input wire logic link_layer_up_flag,
    input wire logic phy_link_up,
    input wire logic fc_init_done,
    input wire dllp_pkg::dllp_t tx_dllp,
    input wire logic tx_dllp_valid,
    input wire logic tx_dllp_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_handshake;
        tx_dllp_valid && tx_dllp_ready;
    endsequence
    sequence s_pulse;
        packet_sent ##1 !packet_sent;
    endsequence
    AST_IDLE_NO_SEND: assert property (!tx_dllp_valid &&
        send_cmd inside {2'h0, 2'h3} |=> !tx_dllp_valid) else $error("idle sent");
    AST_TAKE_CAUSE: assert property ($rose(tx_dllp_valid) |->
        $past(link_layer_active_flag) && $past(send_cmd) == tx_dllp.kind)
        else $error("bad take");
    AST_PM_BODY: assert property ($rose(tx_dllp_valid) &&
        tx_dllp.kind == 2'h1 |-> tx_dllp.pm_type == $past(pm_type)
        && tx_dllp.payload == 24'h0) else $error("bad pm packet");
    AST_VENDOR_BODY: assert property ($rose(tx_dllp_valid) &&
        tx_dllp.kind == 2'h2 |-> tx_dllp.payload == $past(vendor_payload)
        && tx_dllp.pm_type == 3'h0) else $error("bad vendor packet");
    AST_SENT_PULSE: assert property (s_handshake |=> s_pulse)
        else $error("no sent pulse");
    AST_SENT_CAUSE: assert property (packet_sent |->
        $past(tx_dllp_valid && tx_dllp_ready)) else $error("stray sent");
    AST_VALID_HOLD: assert property (tx_dllp_valid && !tx_dllp_ready |=>
        (tx_dllp_valid && $stable(tx_dllp)) || !link_layer_active_flag)
        else $error("packet dropped");
    AST_DROP: assert property (!phy_link_up |=>
        link_layer_inactive_flag) else $error("not inactive");
    AST_INIT_CAUSE: assert property ($rose(link_layer_initialising_flag)
        |-> $past(link_layer_inactive_flag) && $past(phy_link_up))
        else $error("bad init");
    AST_ACTIVE_CAUSE: assert property ($rose(link_layer_active_flag)
        |-> $past(link_layer_initialising_flag) && $past(fc_init_done))
        else $error("bad active");
    AST_UP: assert property (link_layer_up_flag |->
        link_layer_active_flag) else $error("up without active");
    AST_ONE_HOT: assert property ($onehot({link_layer_inactive_flag,
        link_layer_initialising_flag, link_layer_active_flag}))
        else $error("state flags not one-hot");
endmodule
bind link_layer_dllp_request_status dllp_req_chk i_dllp_req_chk (
    .sys_clk(sys_clk), .srst(srst), .send_cmd(send_cmd), .pm_type(pm_type),
    .vendor_payload(vendor_payload), .packet_sent(packet_sent),
    .link_layer_inactive_flag(link_layer_inactive_flag),
    .link_layer_initialising_flag(link_layer_initialising_flag),
    .link_layer_active_flag(link_layer_active_flag),
    .link_layer_up_flag(link_layer_up_flag), .phy_link_up(phy_link_up),
    .fc_init_done(fc_init_done), .tx_dllp(tx_dllp),
    .tx_dllp_valid(tx_dllp_valid), .tx_dllp_ready(tx_dllp_ready));
`default_nettype wire

/* test/user_req_model.sv */
// Behavioural user logic that issues link-layer packet requests.
`default_nettype none
module user_req_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic go,
    input wire logic abort,
    input wire logic [1:0] go_kind,
    input wire logic [2:0] go_pm,
    input wire logic [23:0] go_pay,
    input wire logic packet_sent,
    output logic [1:0] send_cmd,
    output logic [2:0] pm_type,
    output logic [23:0] vendor_payload,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // Abort lets a scenario withdraw a request that is never answered; real
    // user logic would only ever wait for the acknowledge. The reserved
    // command is never put on the pins, so such a request stays idle.
    always_ff @(posedge sys_clk) begin
        if (srst || abort) begin
            send_cmd <= dllp_pkg::CMD_NONE;
            pm_type <= 3'h0;
            vendor_payload <= 24'h0;
            busy <= 1'b0;
        end else if (!busy && go) begin
            send_cmd <= (go_kind == dllp_pkg::CMD_RESERVED) ?
                dllp_pkg::CMD_NONE : go_kind;
            pm_type <= go_pm;
            vendor_payload <= go_pay;
            busy <= 1'b1;
        end else if (busy && packet_sent) begin
            send_cmd <= dllp_pkg::CMD_NONE;
            pm_type <= ~pm_type;
            vendor_payload <= ~vendor_payload;
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* test/link_layer_dllp_request_status_test.sv */
// Self-checking bench for the link-layer packet request block.
`default_nettype none
module link_layer_dllp_request_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, srst, go, abort, sent, busy, phy_up, fc_done, txv, tx_rdy;
    logic f_ina, f_ini, f_act, f_up;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] cmd, go_kind, bresp, rresp, r;
    logic [2:0] pmt, go_pm;
    logic [3:0] awaddr, araddr, wstrb;
    logic [23:0] pay, go_pay;
    logic [31:0] wdata, rdata, d;
    dllp_pkg::dllp_t txd;
    int err_count, comparisons;
    link_layer_dllp_request_status i_link_layer_dllp_request_status (
        .sys_clk(sys_clk), .srst(srst), .send_cmd(cmd), .pm_type(pmt),
        .vendor_payload(pay), .packet_sent(sent),
        .link_layer_inactive_flag(f_ina), .link_layer_initialising_flag(f_ini),
        .link_layer_active_flag(f_act), .link_layer_up_flag(f_up),
        .phy_link_up(phy_up), .fc_init_done(fc_done), .tx_dllp(txd),
        .tx_dllp_valid(txv), .tx_dllp_ready(tx_rdy), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    user_req_model i_user_req_model (.sys_clk(sys_clk), .srst(srst), .go(go),
        .abort(abort), .go_kind(go_kind), .go_pm(go_pm), .go_pay(go_pay),
        .packet_sent(sent), .send_cmd(cmd), .pm_type(pmt),
        .vendor_payload(pay), .busy(busy));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Response ready stays high between transfers, so a call that follows
    // another never lowers and raises it in the same step.
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        r = rresp;
        d = rdata;
    endtask
    task automatic send_pkt(input logic [1:0] k, input logic [2:0] p,
            input logic [23:0] v);
        dllp_pkg::dllp_t e;
        e = '{k, (k == 2'h1) ? p : 3'h0, (k == 2'h2) ? v : 24'h0};
        {go_kind, go_pm, go_pay} <= {k, p, v};
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        while (txv !== 1'b1) begin
            @(posedge sys_clk);
        end
        chk(32'(txd), 32'(e));
        repeat (2) @(posedge sys_clk);
        chk(32'(txv), 32'h1);
        tx_rdy <= 1'b1;
        @(posedge sys_clk);
        tx_rdy <= 1'b0;
        @(posedge sys_clk);
        chk(32'(sent), 32'h1);
        @(posedge sys_clk);
        chk(32'(sent), 32'h0);
    endtask
    task automatic t_reset;
        chk(32'({f_ina, f_ini, f_act, f_up}), 32'h8);
        wstrb <= 4'h0;
        wr(4'h0, 32'h3);
        chk(32'(r), 32'h0);
        wstrb <= 4'hf;
        rd(4'h0);
        chk(d, 32'h0);
        rd(4'h8);
        chk(32'(r), 32'h2);
        chk(d, 32'h0);
        wr(4'h4, 32'hffff_ffff);
        chk(32'(r), 32'h0);
        rd(4'h4);
        chk(d, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_link;
        phy_up <= 1'b1;
        wr(4'h0, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(32'({f_ina, f_ini, f_act}), 32'h2);
        fc_done <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(32'({f_ina, f_ini, f_act, f_up}), 32'h2);
        wr(4'h0, 32'h3);
        @(posedge sys_clk);
        chk(32'(f_up), 32'h1);
        $display("test link done");
    endtask
    task automatic t_send;
        logic [2:0] codes [4];
        codes = '{3'h0, 3'h1, 3'h3, 3'h4};
        foreach (codes[i]) send_pkt(2'h1, codes[i], 24'h5a_5a5a);
        send_pkt(2'h2, 3'h7, 24'hc3_a51e);
        rd(4'h4);
        chk(32'({d[31:16], d[3:0]}), 32'h5c);
        $display("test send done");
    endtask
    task automatic t_reserved_drop;
        {go_kind, go} <= {2'h3, 1'b1};
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (10) begin
            @(posedge sys_clk);
            chk(32'(txv), 32'h0);
        end
        abort <= 1'b1;
        @(posedge sys_clk);
        {abort, go_kind, go} <= {1'b0, 2'h2, 1'b1};
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (3) @(posedge sys_clk);
        phy_up <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(32'({f_ina, f_ini, f_act, txv, sent}), 32'h10);
        $display("test reserved and drop done");
    endtask
    task automatic end_of_test;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        {srst, go, abort, go_kind, go_pm, go_pay} = {1'b1, 31'h0};
        {phy_up, fc_done, tx_rdy, awvalid, wvalid, bready} = 6'h0;
        {arvalid, rready, awaddr, araddr, wdata, wstrb} = {42'h0, 4'hf};
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_link();
        t_send();
        t_reserved_drop();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
